/* File: hdl/glue_consts.svh */
// constants shared by the disk controller glue ends
`ifndef GLUE_CONSTS_SVH
`define GLUE_CONSTS_SVH
`define GLUE_CLK_NS           10
`define GLUE_OSC_MHZ          30
`define GLUE_CTRL_DIV_MOD     4'h3
`define GLUE_CTRL_DIV_PLAIN   4'h2
`define GLUE_BUF_DIV_MOD      4'h9
`define GLUE_BUF_DIV_PLAIN    4'h6
`define GLUE_RD_DATA_NS       140
`define GLUE_SYNC_STAGES      3
`define GLUE_STROBE_CYCLES    \
	((`GLUE_RD_DATA_NS + `GLUE_CLK_NS - 1) / `GLUE_CLK_NS + `GLUE_SYNC_STAGES)
`define GLUE_SETTLE_CYCLES    4'h6
`define GLUE_PORT_DATA        2'h0
`define GLUE_PORT_STATUS      2'h1
`define GLUE_PORT_DRIVE       2'h2
`define GLUE_PORT_CTRL        2'h3
`define GLUE_STAT_BUSY_BIT    0
`define GLUE_STAT_FAULT_BIT   1
`define GLUE_REG_CMD          12'h000
`define GLUE_REG_STATUS       12'h004
`define GLUE_REG_CTRL         12'h008
`define GLUE_CMD_PORT_LSB     8
`define GLUE_CMD_WRITE_BIT    10
`define GLUE_CMD_DHS_BIT      11
`define GLUE_CMD_RESET        12'h000
`define GLUE_BUF_ADDR_RESET   11'h000
`endif

/* File: hdl/glue_pkg.sv */
// types shared by the disk controller glue ends
package glue_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [10:0] buf_addr_t;
	typedef enum logic [2:0]
	{
		DEV_IDLE   = 3'b001,
		DEV_STROBE = 3'b010,
		DEV_HOLD   = 3'b100
	} dev_state_e;
	typedef enum logic [3:0]
	{
		H_IDLE    = 4'b0001,
		H_SETUP   = 4'b0010,
		H_STROBE  = 4'b0100,
		H_RELEASE = 4'b1000
	} host_state_e;
endpackage

/* File: hdl/glue_if.sv */
// host channel between the host end and the glue device end
`timescale 1ns/1ps
interface glue_if;
	logic [7:0] host_data_h;
	logic       host_data_h_oe;
	logic [7:0] host_data_d;
	logic       host_data_d_oe;
	logic [7:0] host_data_bus;
	logic       host_io_write_strobe_n;
	logic       host_io_read_strobe_n;
	logic       port_select_n;
	logic [1:0] host_address;
	logic       host_reset_in;
	logic       drive_head_select_n;
	logic       channel_ready;
	logic       external_buffer_enable;

	// resolved level of the shared data wires; idle bus floats high
	assign host_data_bus = host_data_d_oe ? host_data_d :
		host_data_h_oe ? host_data_h : 8'hFF;

	modport device
	(
		input  host_data_bus, host_io_write_strobe_n, host_io_read_strobe_n,
		input  port_select_n, host_address, host_reset_in,
		input  drive_head_select_n,
		output host_data_d, host_data_d_oe, channel_ready,
		output external_buffer_enable
	);
	modport host
	(
		input  host_data_bus, channel_ready, external_buffer_enable,
		output host_data_h, host_data_h_oe, host_io_write_strobe_n,
		output host_io_read_strobe_n, port_select_n, host_address,
		output host_reset_in, drive_head_select_n
	);
endinterface

/* File: hdl/clock_divider.sv */
// programmable clock divider with a clock-shaped output and a tick
`timescale 1ns/1ps
module clock_divider
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] divisor,
	output logic            clk_q,
	output logic            tick_q
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic       wrap;

	assign wrap  = (cnt_q >= divisor - 4'h1);
	assign cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= 4'h0;
			clk_q  <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			clk_q  <= (cnt_d < {1'b0, divisor[3:1]});
			tick_q <= wrap;
		end
	end
endmodule // clock_divider

/* File: hdl/disk_glue_device.sv */
// glue device end: host port, sector buffer control, clock generation
`include "glue_consts.svh"
`timescale 1ns/1ps
module disk_glue_device
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	glue_if.device                   link,
	input  wire logic                modulation_select,
	input  wire logic                busy,
	input  wire logic                write_fault_in,
	input  wire logic                bus_ask_n,
	input  wire glue_pkg::byte_t     local_data_in,
	output glue_pkg::byte_t          local_data_out,
	output logic                     local_data_oe,
	output glue_pkg::buf_addr_t      buffer_address,
	output logic                     buffer_write_n,
	output logic                     buffer_read_n,
	output logic                     controller_chip_select_n,
	output logic                     write_command_n,
	output logic                     controller_reset_n,
	output logic [3:0]               head_number,
	output logic [1:0]               disk_number,
	output logic                     bus_grant_n,
	output logic                     controller_clock_out,
	output logic                     buffer_clock
);
	import glue_pkg::*;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [26:0] s1_q;
	logic [26:0] s2_q;
	byte_t       h_byte;
	byte_t       l_byte;
	logic        busy_s;
	logic        fault_s;
	logic        wr_n_s;
	logic        rd_n_s;
	logic        sel_n_s;
	logic [1:0]  port_s;
	logic        controller_reset_n_s;
	logic        dhs_n_s;
	logic        ask_n_s;
	logic        mod_s;

	assign {h_byte, l_byte, busy_s, fault_s, wr_n_s, rd_n_s, sel_n_s, port_s,
		controller_reset_n_s, dhs_n_s, ask_n_s, mod_s} = s2_q;

	// ----------------------------------------------------------------
	// clock generation
	// ----------------------------------------------------------------
	logic buf_tick;

	clock_divider u_ctrl_div
	(
		.pclk    (pclk),
		.presetn (presetn),
		.divisor (mod_s ? `GLUE_CTRL_DIV_MOD : `GLUE_CTRL_DIV_PLAIN),
		.clk_q   (controller_clock_out),
		.tick_q  ()
	);

	clock_divider u_buf_div
	(
		.pclk    (pclk),
		.presetn (presetn),
		.divisor (mod_s ? `GLUE_BUF_DIV_MOD : `GLUE_BUF_DIV_PLAIN),
		.clk_q   (buffer_clock),
		.tick_q  (buf_tick)
	);

	// ----------------------------------------------------------------
	// host port decode
	// ----------------------------------------------------------------
	dev_state_e state_q;
	dev_state_e state_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic       ready_q, ready_d;
	logic       bw_n_d, br_n_d, cs_n_d, wc_n_d;
	logic       loe_d;
	byte_t      lout_d;
	byte_t      hout_q, hout_d;
	logic       hoe_q, hoe_d;
	logic       ext_q;
	buf_addr_t  addr_d;
	logic [3:0] head_d;
	logic [1:0] disk_d;
	logic       isbuf_q, isbuf_d;
	logic       isrd_q, isrd_d;

	wire strobe_on  = !wr_n_s || !rd_n_s;
	wire is_wr      = !wr_n_s;
	wire is_rd      = !rd_n_s;
	wire req        = !sel_n_s && strobe_on && !controller_reset_n_s
		&& bus_grant_n;
	wire port_local = (port_s == `GLUE_PORT_DATA)
		|| (port_s == `GLUE_PORT_CTRL);
	wire last       = (cnt_q == 5'h01);
	wire [7:0] status_byte = {6'h00, fault_s, busy_s};
	wire [7:0] drive_byte  = {2'h0, disk_number, head_number};

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		ready_d = ready_q;
		bw_n_d  = 1'b1;
		br_n_d  = 1'b1;
		cs_n_d  = 1'b1;
		wc_n_d  = write_command_n;
		loe_d   = 1'b0;
		lout_d  = local_data_out;
		hout_d  = hout_q;
		hoe_d   = 1'b0;
		addr_d  = buffer_address;
		head_d  = head_number;
		disk_d  = disk_number;
		isbuf_d = isbuf_q;
		isrd_d  = isrd_q;
		case (state_q)
			DEV_IDLE:
				if (req)
				begin
					isrd_d  = is_rd;
					isbuf_d = (port_s == `GLUE_PORT_DATA);
					lout_d  = h_byte;
					if (port_local)
					begin
						state_d = DEV_STROBE;
						cnt_d   = 5'(`GLUE_STROBE_CYCLES);
						ready_d = 1'b0;
						wc_n_d  = !((port_s == `GLUE_PORT_CTRL) && is_wr);
					end
					else
					begin
						state_d = DEV_HOLD;
						// read data goes out with the take, so the host's
						// synced copy of the bus already holds it
						hoe_d   = is_rd;
						if (port_s == `GLUE_PORT_STATUS)
						begin
							hout_d = status_byte;
							if (is_wr)
								addr_d = `GLUE_BUF_ADDR_RESET;
						end
						else
						begin
							hout_d = drive_byte;
							if (is_wr && !dhs_n_s)
								{disk_d, head_d} = h_byte[5:0];
						end
					end
				end
			DEV_STROBE:
			begin
				cnt_d  = cnt_q - 5'h01;
				loe_d  = !isrd_q && !last;
				bw_n_d = !(isbuf_q && !isrd_q && !last);
				br_n_d = !(isbuf_q && isrd_q && !last);
				cs_n_d = !(!isbuf_q && !last);
				if (last)
				begin
					state_d = DEV_HOLD;
					ready_d = 1'b1;
					// bus driven in the same cycle ready rises
					hoe_d   = isrd_q;
					wc_n_d  = 1'b1;
					if (isrd_q)
						hout_d = l_byte;
					if (isbuf_q)
						addr_d = buffer_address + 11'h001;
				end
			end
			DEV_HOLD:
				if (sel_n_s || !strobe_on)
					state_d = DEV_IDLE;
				else
					hoe_d = isrd_q && is_rd;
			default:
				state_d = DEV_IDLE;
		endcase
		if (controller_reset_n_s)
		begin
			addr_d = `GLUE_BUF_ADDR_RESET;
			head_d = 4'h0;
			disk_d = 2'h0;
			wc_n_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q                     <= '1;
			s2_q                     <= '1;
			state_q                  <= DEV_IDLE;
			cnt_q                    <= 5'h00;
			ready_q                  <= 1'b1;
			buffer_write_n           <= 1'b1;
			buffer_read_n            <= 1'b1;
			controller_chip_select_n <= 1'b1;
			write_command_n          <= 1'b1;
			local_data_oe            <= 1'b0;
			local_data_out           <= 8'h00;
			hout_q                   <= 8'h00;
			hoe_q                    <= 1'b0;
			ext_q                    <= 1'b0;
			buffer_address           <= `GLUE_BUF_ADDR_RESET;
			head_number              <= 4'h0;
			disk_number              <= 2'h0;
			isbuf_q                  <= 1'b0;
			isrd_q                   <= 1'b0;
			controller_reset_n       <= 1'b0;
			bus_grant_n              <= 1'b1;
		end
		else
		begin
			s1_q <= {link.host_data_bus, local_data_in, busy, write_fault_in,
				link.host_io_write_strobe_n, link.host_io_read_strobe_n,
				link.port_select_n, link.host_address, link.host_reset_in,
				link.drive_head_select_n, bus_ask_n, modulation_select};
			s2_q                     <= s1_q;
			state_q                  <= state_d;
			cnt_q                    <= cnt_d;
			ready_q                  <= ready_d;
			buffer_write_n           <= bw_n_d;
			buffer_read_n            <= br_n_d;
			controller_chip_select_n <= cs_n_d;
			write_command_n          <= wc_n_d;
			local_data_oe            <= loe_d;
			local_data_out           <= lout_d;
			hout_q                   <= hout_d;
			hoe_q                    <= hoe_d;
			ext_q                    <= !sel_n_s && strobe_on;
			buffer_address           <= addr_d;
			head_number              <= head_d;
			disk_number              <= disk_d;
			isbuf_q                  <= isbuf_d;
			isrd_q                   <= isrd_d;
			controller_reset_n       <= !controller_reset_n_s;
			if (buf_tick)
				bus_grant_n <= ask_n_s;
		end
	end

	assign link.channel_ready          = ready_q;
	assign link.host_data_d            = hout_q;
	assign link.host_data_d_oe         = hoe_q;
	assign link.external_buffer_enable = ext_q;
endmodule // disk_glue_device

/* File: hdl/disk_glue_host.sv */
// glue host end: APB command registers driving the host channel
`include "glue_consts.svh"
`timescale 1ns/1ps
module disk_glue_host
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	glue_if.host             link
);
	import glue_pkg::*;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	host_state_e state_q;
	logic [11:0] cmd_q;
	logic        rst_q;
	byte_t       rdata_q;
	logic [3:0]  cnt_q;
	logic [8:0]  s1_q;
	logic [8:0]  s2_q;

	wire busy_w  = (state_q != H_IDLE);
	wire setup   = psel && !penable;
	wire take_wr = psel && penable && pready && pwrite;
	wire hit_cmd = (paddr == `GLUE_REG_CMD);
	wire hit_sta = (paddr == `GLUE_REG_STATUS);
	wire hit_ctl = (paddr == `GLUE_REG_CTRL);
	wire [31:0] rmux = hit_cmd ? {20'h00000, cmd_q} :
		hit_sta ? {16'h0000, rdata_q, 7'h00, busy_w} :
		hit_ctl ? {31'h0, rst_q} : 32'h00000000;
	wire ready_s = s2_q[8];
	wire cmd_wr  = cmd_q[`GLUE_CMD_WRITE_BIT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
			rst_q   <= 1'b0;
		end
		else
		begin
			pready <= setup;
			if (setup)
			begin
				prdata  <= rmux;
				pslverr <= !(hit_cmd || hit_sta || hit_ctl);
			end
			if (take_wr && hit_ctl)
				rst_q <= pwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// host channel sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q                     <= H_IDLE;
			cmd_q                       <= `GLUE_CMD_RESET;
			cnt_q                       <= 4'h0;
			rdata_q                     <= 8'h00;
			s1_q                        <= '1;
			s2_q                        <= '1;
			link.port_select_n          <= 1'b1;
			link.host_io_write_strobe_n <= 1'b1;
			link.host_io_read_strobe_n  <= 1'b1;
			link.drive_head_select_n    <= 1'b1;
			link.host_address           <= 2'h0;
			link.host_data_h            <= 8'h00;
			link.host_data_h_oe         <= 1'b0;
			link.host_reset_in          <= 1'b0;
		end
		else
		begin
			s1_q               <= {link.channel_ready, link.host_data_bus};
			s2_q               <= s1_q;
			link.host_reset_in <= rst_q;
			case (state_q)
				H_IDLE:
					if (take_wr && hit_cmd)
					begin
						cmd_q   <= pwdata[11:0];
						state_q <= H_SETUP;
					end
				H_SETUP:
				begin
					link.port_select_n       <= 1'b0;
					link.host_address        <= cmd_q[`GLUE_CMD_PORT_LSB +: 2];
					link.drive_head_select_n <= !cmd_q[`GLUE_CMD_DHS_BIT];
					link.host_data_h         <= cmd_q[7:0];
					link.host_data_h_oe      <= cmd_wr;
					state_q                  <= H_STROBE;
					cnt_q                    <= `GLUE_SETTLE_CYCLES;
				end
				H_STROBE:
				begin
					link.host_io_write_strobe_n <= !cmd_wr;
					link.host_io_read_strobe_n  <= cmd_wr;
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else if (ready_s && (!link.host_io_write_strobe_n
						|| !link.host_io_read_strobe_n))
					begin
						rdata_q                     <= s2_q[7:0];
						link.host_io_write_strobe_n <= 1'b1;
						link.host_io_read_strobe_n  <= 1'b1;
						state_q                     <= H_RELEASE;
					end
				end
				H_RELEASE:
				begin
					link.port_select_n       <= 1'b1;
					link.drive_head_select_n <= 1'b1;
					link.host_data_h_oe      <= 1'b0;
					state_q                  <= H_IDLE;
				end
				default:
					state_q <= H_IDLE;
			endcase
		end
	end
endmodule // disk_glue_host

/* File: verification/disk_glue_chk.sv */
// concurrent checks on the host channel and device pins of the glue
`timescale 1ns/1ps
module disk_glue_chk
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                port_select_n,
	input wire logic                host_reset_in,
	input wire logic                channel_ready,
	input wire logic                modulation_select,
	input wire logic                bus_ask_n,
	input wire glue_pkg::buf_addr_t buffer_address,
	input wire logic                buffer_write_n,
	input wire logic                buffer_read_n,
	input wire logic                controller_chip_select_n,
	input wire logic                controller_reset_n,
	input wire logic [3:0]          head_number,
	input wire logic [1:0]          disk_number,
	input wire logic                bus_grant_n,
	input wire logic                controller_clock_out,
	input wire logic                buffer_clock
);
	import glue_pkg::*;
	logic [3:0] ms_cnt_q;
	logic       ms_last_q;
	// clock ratios are only judged once the select has settled
	wire        ms_steady = ms_cnt_q == 4'hF;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt_q  <= 4'h0;
			ms_last_q <= 1'b0;
		end
		else
		begin
			ms_last_q <= modulation_select;
			ms_cnt_q  <= (modulation_select != ms_last_q) ? 4'h0 :
				ms_cnt_q + {3'h0, !ms_steady};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence low_16(s);
		!s [*8] ##1 !s [*8] ##1 s;
	endsequence
	chk_reset_drive: assert property (
		host_reset_in [*4] |-> !controller_reset_n)
		else $error("controller reset not low under host reset");
	chk_reset_clear: assert property (
		!controller_reset_n [*2] |-> buffer_address == 11'h000 &&
		head_number == 4'h0 && disk_number == 2'h0)
		else $error("registers not cleared by host reset");
	chk_unsel_idle: assert property (
		port_select_n [*4] |-> buffer_write_n && buffer_read_n &&
		controller_chip_select_n)
		else $error("access while port not selected");
	chk_ready_wait: assert property (
		$fell(buffer_write_n) || $fell(buffer_read_n) |-> !channel_ready)
		else $error("ready high during buffer strobe");
	chk_write_len: assert property (
		$fell(buffer_write_n) |-> low_16(buffer_write_n) ##0 channel_ready)
		else $error("buffer write strobe length wrong");
	chk_cs_len: assert property (
		$fell(controller_chip_select_n) |-> low_16(controller_chip_select_n))
		else $error("chip select length wrong");
	chk_addr_step: assert property (
		$rose(buffer_write_n) || $rose(buffer_read_n) |->
		buffer_address == buf_addr_t'($past(buffer_address) + 11'h001))
		else $error("buffer address did not advance by one");
	chk_ctrl_clk: assert property (
		$rose(controller_clock_out) && ms_steady |->
		##2 controller_clock_out == !$past(modulation_select, 2))
		else $error("controller clock ratio wrong");
	chk_buf_clk: assert property (
		$rose(buffer_clock) && ms_steady |->
		buffer_clock [*3] ##1 buffer_clock == $past(modulation_select, 3))
		else $error("buffer clock ratio wrong");
	chk_grant_time: assert property (
		$fell(bus_ask_n) |-> ##[1:13] !bus_grant_n)
		else $error("bus grant late");
endmodule // disk_glue_chk

/* File: verification/disk_glue_tb_top.sv */
// self-checking bench joining the host end and device end of the glue
`include "glue_consts.svh"
`timescale 1ns/1ps
module disk_glue_tb_top;
	import glue_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, err, saw_cs, saw_wc, saw_ext;
	logic [31:0] rd;
	logic        modulation_select = 1'b0;
	logic        busy = 1'b0;
	logic        write_fault_in = 1'b0;
	logic        bus_ask_n = 1'b1;
	byte_t       local_data_in = 8'h00;
	byte_t       local_data_out, last_wr, d;
	buf_addr_t   buffer_address;
	logic        local_data_oe, buffer_write_n, buffer_read_n;
	logic        controller_chip_select_n, write_command_n, controller_reset_n;
	logic [3:0]  head_number;
	logic [1:0]  disk_number;
	logic        bus_grant_n, controller_clock_out, buffer_clock;
	int          bad_count = 0;
	int          tests_run = 0;
	int          cc, bc, n;
	always #5 pclk = ~pclk;
	glue_if link ();
	disk_glue_host disk_glue_host_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
	disk_glue_device disk_glue_device_inst (.pclk, .presetn, .link(link),
		.modulation_select, .busy, .write_fault_in, .bus_ask_n,
		.local_data_in, .local_data_out, .local_data_oe, .buffer_address,
		.buffer_write_n, .buffer_read_n, .controller_chip_select_n,
		.write_command_n, .controller_reset_n, .head_number, .disk_number,
		.bus_grant_n, .controller_clock_out, .buffer_clock);
	disk_glue_chk disk_glue_chk_inst (.pclk, .presetn,
		.port_select_n(link.port_select_n), .host_reset_in(link.host_reset_in),
		.channel_ready(link.channel_ready), .modulation_select, .bus_ask_n,
		.buffer_address, .buffer_write_n, .buffer_read_n,
		.controller_chip_select_n, .controller_reset_n, .head_number,
		.disk_number, .bus_grant_n, .controller_clock_out, .buffer_clock);
	// ----------------------------------------------------------------
	// local bus monitor
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (!buffer_write_n && local_data_oe)
			last_wr = local_data_out;
		if (link.external_buffer_enable)
			saw_ext = 1'b1;
		if (!controller_chip_select_n)
		begin
			saw_cs = 1'b1;
			saw_wc = saw_wc | !write_command_n;
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang(input int k);
		if (k > 0)
		begin
			cmp(32'h0, 32'h1);
			close_out();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		hang(int'(k >= 50));
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic host_cmd(input logic [1:0] port, input logic w, dhs,
		input byte_t v);
		int k;
		apb(1'b1, `GLUE_REG_CMD, {20'h0, dhs, w, port, v});
		repeat (2) @(posedge pclk);
		k = 0;
		do
		begin
			apb(1'b0, `GLUE_REG_STATUS, 32'h0);
			k++;
		end
		while (rd[0] !== 1'b0 && k < 40);
		hang(int'(k >= 40));
	endtask
	task automatic count_rises;
		logic pc, pb;
		#1;
		cc = 0;
		bc = 0;
		pc = controller_clock_out;
		pb = buffer_clock;
		repeat (36)
		begin
			@(posedge pclk);
			#1;
			cc += int'(controller_clock_out && !pc);
			bc += int'(buffer_clock && !pb);
			pc = controller_clock_out;
			pb = buffer_clock;
		end
	endtask
	function automatic int rises(input logic m, input logic buf_clk);
		return 36 / (buf_clk ? (m ? 9 : 6) : (m ? 3 : 2));
	endfunction
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(2));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		cmp(controller_reset_n, 1'b1);
		apb(1'b0, 12'hFFC, 32'h0);
		cmp(err, 1'b1);
		cmp(rd, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			busy <= i[0];
			write_fault_in <= i[1];
			host_cmd(2'h1, 1'b0, 1'b0, 8'h00);
			cmp(rd[15:8], {6'h0, i[1], i[0]});
		end
		for (int i = 0; i < 3; i++)
		begin
			d = 8'($urandom);
			host_cmd(2'h2, 1'b1, 1'b1, d);
			cmp({disk_number, head_number}, d[5:0]);
			host_cmd(2'h2, 1'b1, 1'b0, ~d);
			host_cmd(2'h2, 1'b0, 1'b0, 8'h00);
			cmp(rd[15:8], {2'h0, d[5:0]});
		end
		for (int p = 0; p < 2; p++)
		begin
			host_cmd(2'h1, 1'b1, 1'b0, 8'h00);
			cmp(buffer_address, 11'h000);
			for (int i = 1; i < 4; i++)
			begin
				d = 8'($urandom);
				local_data_in <= ~d;
				host_cmd(2'h0, p == 0, 1'b0, d);
				cmp(p ? rd[15:8] : last_wr, p ? byte_t'(~d) : d);
				cmp(buffer_address, i);
			end
		end
		for (int w = 0; w < 2; w++)
		begin
			saw_cs = 1'b0;
			saw_wc = 1'b0;
			saw_ext = 1'b0;
			host_cmd(2'h3, w[0], 1'b0, 8'($urandom));
			cmp(saw_cs, 1'b1);
			cmp(saw_wc, w[0]);
			cmp(saw_ext, 1'b1);
			cmp(link.external_buffer_enable, 1'b0);
		end
		apb(1'b1, `GLUE_REG_CTRL, 32'h1);
		repeat (6) @(posedge pclk);
		cmp(controller_reset_n, 1'b0);
		cmp({buffer_address, disk_number, head_number}, 17'h0);
		apb(1'b1, `GLUE_REG_CTRL, 32'h0);
		repeat (6) @(posedge pclk);
		cmp(controller_reset_n, 1'b1);
		for (int m = 0; m < 2; m++)
		begin
			modulation_select <= m[0];
			repeat (30) @(posedge pclk);
			count_rises();
			cmp(cc, rises(m[0], 1'b0));
			cmp(bc, rises(m[0], 1'b1));
			@(posedge pclk);
			bus_ask_n <= 1'b0;
			n = 0;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (bus_grant_n !== 1'b0 && n < 14);
			cmp(bus_grant_n, 1'b0);
			repeat (6) @(posedge pclk);
			bus_ask_n <= 1'b1;
			repeat (14) @(posedge pclk);
			cmp(bus_grant_n, 1'b1);
		end
		close_out();
	end
endmodule // disk_glue_tb_top
